// >>> hdl/psc_pkg.sv
// Constants and types for the power save mode controller
package psc_pkg;
	localparam logic [31:0] PSC_ADDR_CTRL = 32'hFFFFF1FE;
	localparam logic [31:0] PSC_ADDR_UNLOCK = 32'hFFFFF1FC;
	localparam logic [31:0] PSC_ADDR_MODESEL = 32'hFFFFF1F8;
	localparam int PSC_NONMASKABLE_RELEASE_DISABLE_BIT = 5;
	localparam int PSC_MASKABLE_RELEASE_DISABLE_BIT = 4;
	localparam int PSC_STB_BIT = 1;
	localparam int PSC_KIND_BIT = 0;
	localparam logic [7:0] PSC_CTRL_RESET = 8'h00;
	localparam logic [7:0] PSC_MODESEL_RESET = 8'h00;
	localparam logic [7:0] PSC_CTRL_WMASK = 8'h32;
	localparam logic [7:0] PSC_UNLOCK_RDATA = 8'h00;
	localparam int PSC_CLK_NS = 40;
	localparam int PSC_STAB_NS = 655360;
	localparam int PSC_STAB_CYCLES = (PSC_STAB_NS + PSC_CLK_NS - 1) / PSC_CLK_NS;
	typedef enum logic [1:0] {PSC_OP_STORE, PSC_OP_SET, PSC_OP_CLR, PSC_OP_NOT} psc_op_t;
	typedef enum logic [2:0] {PSC_ST_RUN, PSC_ST_HALT, PSC_ST_IDLE, PSC_ST_STOP, PSC_ST_WAKE} psc_state_t;
endpackage : psc_pkg

// >>> hdl/psc_power_save.sv
// Power save mode controller: protected control register and clock gating
`timescale 1ns/1ps
`default_nettype none
module psc_power_save
	import psc_pkg::*;
#(
	parameter int STAB_CYCLES = PSC_STAB_CYCLES
)(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [31:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [1:0] reg_op,
	input wire logic [2:0] reg_bit,
	input wire logic [7:0] reg_wdata,
	input wire logic halt_req,
	input wire logic nmi_edge,
	input wire logic int_req_unmasked,
	input wire logic ext_clock,
	input wire logic direct_mode,
	output logic [7:0] reg_rdata,
	output logic intack_inhibit,
	output logic osc_en,
	output logic pll_en,
	output logic periph_clk_en,
	output logic cpu_clk_en,
	output logic oscillator_input_hold_low,
	output logic clk_stable
);
	logic [7:0] power_save_mode_select;
	logic nonmaskable_release_disable;
	logic maskable_release_disable;
	logic standby_request;
	logic stop_kind;
	logic unlock_armed;
	logic [31:0] wake_cnt;
	psc_state_t state;
	psc_state_t next_state;

	wire hit_ctrl = reg_addr == PSC_ADDR_CTRL;
	wire hit_unlock = reg_addr == PSC_ADDR_UNLOCK;
	wire hit_modesel = reg_addr == PSC_ADDR_MODESEL;
	wire is_store = reg_op == PSC_OP_STORE;
	wire [7:0] bit_mask = 8'h01 << reg_bit;
	wire [7:0] ctrl_now = {2'b00, nonmaskable_release_disable, maskable_release_disable, 2'b00,
		standby_request, 1'b0};
	// Bit operations are read-modify-write on the current contents
	function automatic logic [7:0] psc_apply(input logic [1:0] op, input logic [7:0] cur,
		input logic [7:0] mask, input logic [7:0] data);
		case (op)
			PSC_OP_SET: psc_apply = cur | mask;
			PSC_OP_CLR: psc_apply = cur & ~mask;
			PSC_OP_NOT: psc_apply = cur ^ mask;
			default: psc_apply = data;
		endcase
	endfunction : psc_apply
	wire [7:0] modesel_new = psc_apply(reg_op, power_save_mode_select, bit_mask, reg_wdata);
	// Bits 7 and 6 and the unused bits are not stored
	wire [7:0] ctrl_new = psc_apply(reg_op, ctrl_now, bit_mask, reg_wdata) & PSC_CTRL_WMASK;
	wire unlock_store = reg_wr && hit_unlock && is_store;
	wire ctrl_commit = reg_wr && hit_ctrl && unlock_armed;
	wire standby_go = ctrl_commit && ctrl_new[PSC_STB_BIT] && state == PSC_ST_RUN;
	// Disable bits only gate release from IDLE and STOP; HALT ignores them
	wire release_ok = (nmi_edge && !nonmaskable_release_disable)
		|| (int_req_unmasked && !maskable_release_disable);
	wire halt_wake = nmi_edge || int_req_unmasked;
	wire wake_done = wake_cnt >= (STAB_CYCLES - 1);
	wire pll_path = !direct_mode;

	always_comb
	begin
		next_state = state;
		case (state)
			PSC_ST_RUN:
			begin
				if (standby_go)
					next_state = ctrl_new[PSC_STB_BIT] && stop_kind_sel() ? PSC_ST_STOP : PSC_ST_IDLE;
				else if (halt_req)
					next_state = PSC_ST_HALT;
			end
			PSC_ST_HALT:
				if (halt_wake)
					next_state = PSC_ST_RUN;
			PSC_ST_IDLE:
				if (release_ok)
					next_state = PSC_ST_RUN;
			PSC_ST_STOP:
				if (release_ok)
					next_state = PSC_ST_WAKE;
			PSC_ST_WAKE:
				if (wake_done)
					next_state = PSC_ST_RUN;
			default: next_state = PSC_ST_RUN;
		endcase
	end
	// Mode select takes effect only at the moment standby is requested
	function automatic logic stop_kind_sel();
		stop_kind_sel = power_save_mode_select[PSC_KIND_BIT];
	endfunction : stop_kind_sel

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			state <= PSC_ST_RUN;
		else
			state <= next_state;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			power_save_mode_select <= PSC_MODESEL_RESET;
		else if (reg_wr && hit_modesel)
			power_save_mode_select <= modesel_new;
	end

	// Any write after the unlock store other than a further unlock store disarms, so a stray store cannot reach the register later
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			unlock_armed <= 1'b0;
		else if (reg_wr)
			unlock_armed <= unlock_store;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			nonmaskable_release_disable <= PSC_CTRL_RESET[PSC_NONMASKABLE_RELEASE_DISABLE_BIT];
			maskable_release_disable <= PSC_CTRL_RESET[PSC_MASKABLE_RELEASE_DISABLE_BIT];
		end
		else if (ctrl_commit)
		begin
			nonmaskable_release_disable <= ctrl_new[PSC_NONMASKABLE_RELEASE_DISABLE_BIT];
			maskable_release_disable <= ctrl_new[PSC_MASKABLE_RELEASE_DISABLE_BIT];
		end
	end

	// Standby request follows the standby states; it drops as the release leaves them
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			standby_request <= PSC_CTRL_RESET[PSC_STB_BIT];
		else
			standby_request <= next_state == PSC_ST_IDLE || next_state == PSC_ST_STOP;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			stop_kind <= 1'b0;
		else if (standby_go)
			stop_kind <= power_save_mode_select[PSC_KIND_BIT];
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			wake_cnt <= 32'h00000000;
		else if (state == PSC_ST_WAKE)
			wake_cnt <= wake_cnt + 32'h00000001;
		else
			wake_cnt <= 32'h00000000;
	end

	wire run_st = state == PSC_ST_RUN;
	wire halt_st = state == PSC_ST_HALT;
	wire stop_st = state == PSC_ST_STOP;
	wire wake_st = state == PSC_ST_WAKE;
	// Oscillator only runs with a resonator; it restarts during the wake wait
	wire next_osc = pll_path && !ext_clock && !stop_st;
	wire next_pll = pll_path && !stop_st;
	wire next_periph = run_st || halt_st;
	wire next_cpu = run_st;
	wire next_hold = direct_mode && stop_st;
	wire [7:0] next_rdata = hit_ctrl ? ctrl_now : hit_modesel ? power_save_mode_select : PSC_UNLOCK_RDATA;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			osc_en <= 1'b0;
			pll_en <= 1'b0;
			periph_clk_en <= 1'b0;
			cpu_clk_en <= 1'b0;
			oscillator_input_hold_low <= 1'b0;
			clk_stable <= 1'b0;
			intack_inhibit <= 1'b0;
			reg_rdata <= 8'h00;
		end
		else
		begin
			osc_en <= next_osc;
			pll_en <= next_pll;
			periph_clk_en <= next_periph;
			cpu_clk_en <= next_cpu;
			oscillator_input_hold_low <= next_hold;
			clk_stable <= !stop_st && !wake_st;
			intack_inhibit <= unlock_store;
			if (reg_rd)
				reg_rdata <= next_rdata;
		end
	end

	default clocking psc_cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_unlock; reg_wr && hit_unlock && is_store; endsequence
	sequence s_ctrl_wr; reg_wr && hit_ctrl; endsequence
	// The bench leaves idle cycles inside the sequence, so key on the armed flag rather than adjacency
	property p_commit;
		unlock_armed && reg_wr && hit_ctrl |=> nonmaskable_release_disable == $past(ctrl_new[PSC_NONMASKABLE_RELEASE_DISABLE_BIT]);
	endproperty
	a_commit: assert property (p_commit) else $error("protected write not committed");
	property p_no_commit;
		s_ctrl_wr and !unlock_armed |=> $stable(maskable_release_disable) && $stable(nonmaskable_release_disable);
	endproperty
	a_no_commit: assert property (p_no_commit) else $error("unprotected write changed control");
	property p_inhibit;
		s_unlock |=> intack_inhibit ##1 (!intack_inhibit || $past(unlock_store));
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("acknowledge not inhibited after unlock");
	property p_bitop_unlock;
		reg_wr && hit_unlock && !is_store |=> !intack_inhibit;
	endproperty
	a_bitop_unlock: assert property (p_bitop_unlock) else $error("bit op armed unlock");
	property p_stop_clocks;
		state == PSC_ST_STOP |=> !osc_en && !pll_en && !periph_clk_en && !cpu_clk_en;
	endproperty
	a_stop_clocks: assert property (p_stop_clocks) else $error("clock running in STOP");
	property p_idle_clocks;
		state == PSC_ST_IDLE && !ext_clock && !direct_mode |=> osc_en && pll_en && !periph_clk_en && !cpu_clk_en;
	endproperty
	a_idle_clocks: assert property (p_idle_clocks) else $error("wrong clocks in IDLE");
	property p_ext_osc;
		ext_clock || direct_mode |=> !osc_en;
	endproperty
	a_ext_osc: assert property (p_ext_osc) else $error("oscillator on with external clock");
	property p_nmi_block;
		state == PSC_ST_STOP && nmi_edge && nonmaskable_release_disable && !int_req_unmasked |=> state == PSC_ST_STOP;
	endproperty
	a_nmi_block: assert property (p_nmi_block) else $error("masked NMI released STOP");
	property p_enter;
		standby_go |=> standby_request ##1 !cpu_clk_en;
	endproperty
	a_enter: assert property (p_enter) else $error("standby not entered");
	property p_wake_wait;
		state == PSC_ST_STOP && release_ok |=> (!cpu_clk_en && !clk_stable) [*8];
	endproperty
	a_wake_wait: assert property (p_wake_wait) else $error("CPU resumed before stabilization");
	property p_idle_release;
		state == PSC_ST_IDLE && release_ok |=> !standby_request ##1 cpu_clk_en;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("IDLE release incomplete");
	property p_kind;
		state == PSC_ST_STOP |-> stop_kind;
	endproperty
	a_kind: assert property (p_kind) else $error("STOP entered with IDLE kind selected");
	property p_halt_clocks;
		state == PSC_ST_HALT |=> periph_clk_en && !cpu_clk_en;
	endproperty
	a_halt_clocks: assert property (p_halt_clocks) else $error("wrong clocks in HALT");
	property p_hold_low;
		state == PSC_ST_STOP && direct_mode |=> oscillator_input_hold_low;
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("oscillator pin not held low in STOP");
	property p_direct_pll;
		direct_mode |=> !pll_en;
	endproperty
	a_direct_pll: assert property (p_direct_pll) else $error("PLL running in direct mode");
	property p_unlock_rd;
		reg_rd && hit_unlock |=> reg_rdata == PSC_UNLOCK_RDATA;
	endproperty
	a_unlock_rd: assert property (p_unlock_rd) else $error("unlock read returned stored data");
	property p_wake_flag;
		state == PSC_ST_WAKE |-> !standby_request;
	endproperty
	a_wake_flag: assert property (p_wake_flag) else $error("standby request still set after release");
	property p_ctrl_rd;
		reg_rd && hit_ctrl |=> (reg_rdata & ~PSC_CTRL_WMASK) == 8'h00;
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("unused control bits read nonzero");
endmodule : psc_power_save
`default_nettype wire

// >>> tb/tb_power_save_mode_control.sv
// Self-checking testbench for the power save mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_power_save_mode_control
	import psc_pkg::*;
;
	localparam int STAB = 10;
	logic sys_clk, rstn, reg_wr, reg_rd, halt_req, nmi_edge, int_req_unmasked, ext_clock, direct_mode;
	logic [31:0] reg_addr;
	logic [1:0] reg_op;
	logic [2:0] reg_bit;
	logic [7:0] reg_wdata, reg_rdata;
	logic intack_inhibit, osc_en, pll_en, periph_clk_en, cpu_clk_en, oscillator_input_hold_low, clk_stable;
	int errors = 0;
	int checked = 0;
	psc_power_save #(.STAB_CYCLES(STAB)) u_psc_power_save (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_op(reg_op), .reg_bit(reg_bit), .reg_wdata(reg_wdata),
		.halt_req(halt_req), .nmi_edge(nmi_edge), .int_req_unmasked(int_req_unmasked), .ext_clock(ext_clock),
		.direct_mode(direct_mode), .reg_rdata(reg_rdata), .intack_inhibit(intack_inhibit), .osc_en(osc_en),
		.pll_en(pll_en), .periph_clk_en(periph_clk_en), .cpu_clk_en(cpu_clk_en),
		.oscillator_input_hold_low(oscillator_input_hold_low), .clk_stable(clk_stable));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	task cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc
	// Strobe drops one cycle later, so back-to-back calls leave one idle cycle
	task wr(input logic [31:0] a, input psc_op_t op, input logic [2:0] b, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_op = op;
		reg_bit = b;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask : wr
	task rd(input logic [31:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		chk(reg_rdata, exp);
	endtask : rd
	// No transfers run on this bench, so the protected sequence never races one
	task prot(input logic [7:0] d);
		wr(PSC_ADDR_UNLOCK, PSC_OP_STORE, 3'h0, d);
		chk({7'h00, intack_inhibit}, 8'h01);
		wr(PSC_ADDR_CTRL, PSC_OP_STORE, 3'h0, d);
	endtask : prot
	// 0 nmi edge, 1 maskable request, 2 halt
	task pls(input int k);
		@(negedge sys_clk);
		nmi_edge = (k == 0);
		int_req_unmasked = (k == 1);
		halt_req = (k == 2);
		@(negedge sys_clk);
		nmi_edge = 1'b0;
		int_req_unmasked = 1'b0;
		halt_req = 1'b0;
	endtask : pls
	task clks(input logic [3:0] exp);
		chk({4'h0, osc_en, pll_en, periph_clk_en, cpu_clk_en}, {4'h0, exp});
	endtask : clks
	task t_reset;
		rd(PSC_ADDR_CTRL, PSC_CTRL_RESET);
		rd(PSC_ADDR_MODESEL, PSC_MODESEL_RESET);
		clks(4'hF);
		chk({7'h00, clk_stable}, 8'h01);
	endtask : t_reset
	task t_protect;
		wr(PSC_ADDR_CTRL, PSC_OP_STORE, 3'h0, 8'h30);
		rd(PSC_ADDR_CTRL, 8'h00);
		wr(PSC_ADDR_UNLOCK, PSC_OP_SET, 3'h0, 8'h00);
		wr(PSC_ADDR_CTRL, PSC_OP_STORE, 3'h0, 8'h30);
		rd(PSC_ADDR_CTRL, 8'h00);
		prot(8'h3D);
		rd(PSC_ADDR_CTRL, 8'h30);
		prot(8'h00);
		rd(PSC_ADDR_CTRL, 8'h00);
	endtask : t_protect
	task t_modesel;
		wr(PSC_ADDR_MODESEL, PSC_OP_SET, 3'h3, 8'h00);
		wr(PSC_ADDR_MODESEL, PSC_OP_NOT, 3'h0, 8'h00);
		rd(PSC_ADDR_MODESEL, 8'h09);
		wr(PSC_ADDR_MODESEL, PSC_OP_CLR, 3'h3, 8'h00);
		rd(PSC_ADDR_MODESEL, 8'h01);
		clks(4'hF);
		wr(PSC_ADDR_MODESEL, PSC_OP_STORE, 3'h0, 8'h00);
		rd(PSC_ADDR_MODESEL, 8'h00);
	endtask : t_modesel
	task t_idle;
		prot(8'h02);
		cyc(5);
		clks(4'hC);
		rd(PSC_ADDR_CTRL, 8'h02);
		pls(0);
		cyc(2);
		clks(4'hF);
		rd(PSC_ADDR_CTRL, 8'h00);
	endtask : t_idle
	// Disable one release source, standby, then show it blocked and the other one working
	task t_mask(input logic [7:0] dis, input int blocked);
		prot(dis);
		pls(2);
		cyc(2);
		clks(4'hE);
		pls(blocked);
		cyc(2);
		clks(4'hF);
		prot(dis | 8'h02);
		cyc(3);
		pls(blocked);
		cyc(3);
		clks(4'hC);
		pls(1 - blocked);
		cyc(2);
		clks(4'hF);
		rd(PSC_ADDR_CTRL, dis);
		prot(8'h00);
	endtask : t_mask
	task t_stop;
		wr(PSC_ADDR_MODESEL, PSC_OP_STORE, 3'h0, 8'h01);
		prot(8'h02);
		cyc(5);
		clks(4'h0);
		chk({7'h00, clk_stable}, 8'h00);
		pls(1);
		cyc(4);
		chk({6'h00, clk_stable, cpu_clk_en}, 8'h00);
		cyc(STAB + 2);
		chk({6'h00, clk_stable, cpu_clk_en}, 8'h03);
		rd(PSC_ADDR_CTRL, 8'h00);
	endtask : t_stop
	task t_ext;
		ext_clock = 1'b1;
		cyc(3);
		clks(4'h7);
		direct_mode = 1'b1;
		cyc(3);
		clks(4'h3);
		pls(2);
		cyc(2);
		clks(4'h2);
		pls(0);
		prot(8'h02);
		cyc(3);
		chk({7'h00, oscillator_input_hold_low}, 8'h01);
		pls(1);
		cyc(STAB + 4);
		chk({7'h00, oscillator_input_hold_low}, 8'h00);
		clks(4'h3);
	endtask : t_ext
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Whole run needs well under a thousand cycles
	initial
	begin
		#(40 * 5000);
		errors++;
		tally_and_finish();
	end
	initial
	begin
		{rstn, reg_wr, reg_rd, halt_req, nmi_edge, int_req_unmasked, ext_clock, direct_mode} = 8'h00;
		reg_addr = 32'h00000000;
		reg_op = 2'h0;
		reg_bit = 3'h0;
		reg_wdata = 8'h00;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		rstn = 1'b1;
		cyc(2);
		t_reset();
		t_protect();
		t_modesel();
		t_idle();
		t_mask(8'h20, 0);
		t_mask(8'h10, 1);
		t_stop();
		t_ext();
		tally_and_finish();
	end
endmodule : tb_power_save_mode_control
`default_nettype wire
